// File: verilog/abdcs_serial.sv
// dual-channel autobaud serial front end with daisy-chain forwarding
`timescale 1ns/1ps
module abdcs_serial (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_pri_rxd,
    output logic o_pri_txd,
    output logic o_sec_txd,
    input wire logic i_fault,
    output logic [7:0] o_cmd_data,
    output logic o_cmd_valid,
    input wire logic [7:0] i_resp_data,
    input wire logic i_resp_valid,
    output logic o_resp_ready,
    output logic o_rate_locked,
    output logic [2:0] o_rate_sel
);
    import abdcs_pkg::*;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [SYNC_DEPTH-1:0] rxd_sync_reg;
    logic [SYNC_DEPTH-1:0] flt_sync_reg;
    logic rxd_reg;
    logic flt_reg;
    logic flt_prev_reg;

    // three stages; a level change counts once stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rxd_sync_reg <= '1;
            flt_sync_reg <= '0;
            rxd_reg <= 1'b1;
            flt_reg <= 1'b0;
            flt_prev_reg <= 1'b0;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[1:0], i_pri_rxd};
            flt_sync_reg <= {flt_sync_reg[1:0], i_fault};
            if (rxd_sync_reg[1] == rxd_sync_reg[2]) begin
                rxd_reg <= rxd_sync_reg[2];
            end
            if (flt_sync_reg[1] == flt_sync_reg[2]) begin
                flt_reg <= flt_sync_reg[2];
            end
            flt_prev_reg <= flt_reg;
        end
    end

    // ****************************************************************
    // rate measurement on the carriage return
    // ****************************************************************
    // the carriage return starts with a start bit and data bit 0 = 1, so
    // the first low pulse is exactly one bit long: measure it and snap
    // to the nearest rate. a pulse nearer no rate is refused and we hunt again.
    abdcs_baud_e baud_state_reg;
    logic [MEAS_W-1:0] meas_reg;
    logic [2:0] rate_reg;
    logic locked_reg;
    logic [2:0] near_idx;
    logic near_ok;
    logic rx_done;
    logic [7:0] rx_byte_reg;
    logic rx_frame_ok_reg;

    // pick the rate whose period lies within a quarter of the measurement
    always_comb begin
        near_idx = 3'd0;
        near_ok = 1'b0;
        for (int k = 0; k < NUM_RATES; k++) begin
            if ((MEAS_W'(abdcs_rate_div(3'(k))) * 4 <= meas_reg * 5) &&
                (meas_reg * 4 <= MEAS_W'(abdcs_rate_div(3'(k))) * 5)) begin
                near_idx = 3'(k);
                near_ok = 1'b1;
            end
        end
    end

    // hunt, measure, confirm the byte, lock for good
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            baud_state_reg <= ABDCS_HUNT;
            meas_reg <= '0;
            rate_reg <= 3'd0;
            locked_reg <= 1'b0;
        end else begin
            case (baud_state_reg)
                ABDCS_HUNT: begin
                    meas_reg <= '0;
                    if (!rxd_reg) begin
                        baud_state_reg <= ABDCS_MEAS;
                    end
                end
                ABDCS_MEAS: begin
                    if (rxd_reg) begin
                        if (near_ok) begin
                            rate_reg <= near_idx;
                            baud_state_reg <= ABDCS_CHECK;
                        end else begin
                            baud_state_reg <= ABDCS_HUNT;
                        end
                    end else if (meas_reg == MEAS_W'(MEAS_MAX)) begin
                        baud_state_reg <= ABDCS_HUNT; // line stuck low
                    end else begin
                        meas_reg <= meas_reg + 1'b1;
                    end
                end
                ABDCS_CHECK: begin
                    // receiver decodes the rest of the frame at the trial rate
                    if (rx_done) begin
                        // frame_ok lands one edge late, so read the stop level itself
                        if (rxd_reg && rx_byte_reg == CHAR_CR) begin
                            locked_reg <= 1'b1;
                            baud_state_reg <= ABDCS_LOCK;
                        end else begin
                            baud_state_reg <= ABDCS_HUNT;
                        end
                    end
                end
                ABDCS_LOCK: begin
                    baud_state_reg <= ABDCS_LOCK;
                end
                default: baud_state_reg <= ABDCS_HUNT;
            endcase
        end
    end

    // ****************************************************************
    // primary receiver, 8n1
    // ****************************************************************
    // during CHECK the receiver joins the frame already past the start bit
    abdcs_rx_e rx_state_reg;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [DIV_W-1:0] bit_div;
    logic rx_enable;
    logic cr_seen;

    assign bit_div = abdcs_rate_div(rate_reg);
    assign rx_enable = locked_reg || baud_state_reg == ABDCS_CHECK;
    assign rx_done = (rx_state_reg == ABDCS_RX_STOP) && (rx_cnt_reg == '0);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rx_state_reg <= ABDCS_RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_byte_reg <= '0;
            rx_frame_ok_reg <= 1'b0;
        end else begin
            case (rx_state_reg)
                ABDCS_RX_IDLE: begin
                    if (baud_state_reg == ABDCS_MEAS && rxd_reg && near_ok) begin
                        // start bit just ended; bit 0 centre lies half a bit on
                        rx_state_reg <= ABDCS_RX_DATA;
                        rx_cnt_reg <= abdcs_rate_div(near_idx) >> 1;
                        rx_bit_reg <= '0;
                    end else if (locked_reg && !rxd_reg) begin
                        rx_state_reg <= ABDCS_RX_START;
                        rx_cnt_reg <= bit_div >> 1;
                    end
                end
                ABDCS_RX_START: begin
                    if (rx_cnt_reg != '0) begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end else if (rxd_reg) begin
                        rx_state_reg <= ABDCS_RX_IDLE; // glitch, not a start bit
                    end else begin
                        rx_state_reg <= ABDCS_RX_DATA;
                        rx_cnt_reg <= bit_div - 1'b1;
                        rx_bit_reg <= '0;
                    end
                end
                ABDCS_RX_DATA: begin
                    if (rx_cnt_reg != '0) begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end else begin
                        rx_byte_reg <= {rxd_reg, rx_byte_reg[7:1]};
                        rx_cnt_reg <= bit_div - 1'b1;
                        if (rx_bit_reg == 4'(DATA_BITS - 1)) begin
                            rx_state_reg <= ABDCS_RX_STOP;
                        end else begin
                            rx_bit_reg <= rx_bit_reg + 1'b1;
                        end
                    end
                end
                ABDCS_RX_STOP: begin
                    if (rx_cnt_reg != '0) begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end else begin
                        rx_frame_ok_reg <= rxd_reg; // stop bit must be high
                        rx_state_reg <= ABDCS_RX_IDLE;
                    end
                end
                default: rx_state_reg <= ABDCS_RX_IDLE;
            endcase
        end
    end

    // frame_ok lands one cycle after the stop sample; flag the byte then
    logic rx_done_d_reg;
    logic [7:0] cmd_data_reg;
    logic cmd_valid_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rx_done_d_reg <= 1'b0;
        end else begin
            rx_done_d_reg <= rx_done && locked_reg;
        end
    end
    assign cr_seen = rx_done_d_reg && rx_frame_ok_reg;

    // ****************************************************************
    // command delivery and forwarding down the chain
    // ****************************************************************
    abdcs_stream_if #(.W(FIFO_W)) fwd_in ();
    abdcs_stream_if #(.W(FIFO_W)) fwd_out ();
    logic kill_pend_reg;
    logic fault_rise;

    assign fault_rise = flt_reg && !flt_prev_reg;

    // host command to core; one-cycle pulse, data held until the next byte
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cmd_data_reg <= '0;
            cmd_valid_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= cr_seen;
            if (cr_seen) begin
                cmd_data_reg <= rx_byte_reg;
            end
        end
    end

    // kill wins the fifo slot; a byte arriving then waits one cycle in
    // a single holding slot. a host byte that finds the fifo full waits
    // there, and is lost only if the next byte arrives before it is taken.
    logic [7:0] hold_data_reg;
    logic hold_valid_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            kill_pend_reg <= 1'b0;
            hold_valid_reg <= 1'b0;
            hold_data_reg <= '0;
        end else begin
            if (fault_rise) begin
                kill_pend_reg <= 1'b1;
            end else if (fwd_in.ready && kill_pend_reg) begin
                kill_pend_reg <= 1'b0;
            end
            if (cr_seen) begin
                hold_valid_reg <= 1'b1;
                hold_data_reg <= rx_byte_reg;
            end else if (fwd_in.ready && !kill_pend_reg) begin
                hold_valid_reg <= 1'b0;
            end
        end
    end
    // a received kill from upstream is forwarded as any other byte, so it
    // relays down every unit of the chain
    assign fwd_in.valid = kill_pend_reg || hold_valid_reg;
    assign fwd_in.data = kill_pend_reg ? CHAR_KILL : hold_data_reg;

    abdcs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fwd_fifo (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .s_in(fwd_in.snk),
        .s_out(fwd_out.src)
    );

    // ****************************************************************
    // transmitters, one per channel
    // ****************************************************************
    // index 0 = primary responses, index 1 = secondary forwarding
    logic [1:0] tx_load;
    logic [1:0] tx_busy;
    logic [1:0] tx_line;
    logic [7:0] tx_src [2];
    assign tx_src[0] = i_resp_data;
    assign tx_src[1] = fwd_out.data;
    assign tx_load[0] = locked_reg && i_resp_valid && !tx_busy[0];
    assign tx_load[1] = locked_reg && fwd_out.valid && !tx_busy[1];
    assign o_resp_ready = tx_load[0];
    assign fwd_out.ready = tx_load[1];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_tx
            abdcs_tx_e st_reg;
            logic [9:0] sh_reg;
            logic [3:0] n_reg;
            logic [DIV_W-1:0] cnt_reg;
            assign tx_busy[c] = (st_reg != ABDCS_TX_IDLE);
            assign tx_line[c] = sh_reg[0];
            // both channels share the locked divider, so a chain of units
            // all run at the host's rate with no accumulated drift
            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    st_reg <= ABDCS_TX_IDLE;
                    sh_reg <= '1;
                    n_reg <= '0;
                    cnt_reg <= '0;
                end else begin
                    case (st_reg)
                        ABDCS_TX_IDLE: begin
                            if (tx_load[c]) begin
                                sh_reg <= {1'b1, tx_src[c], 1'b0};
                                cnt_reg <= bit_div - 1'b1;
                                n_reg <= '0;
                                st_reg <= ABDCS_TX_SHIFT;
                            end
                        end
                        ABDCS_TX_SHIFT: begin
                            if (cnt_reg != '0) begin
                                cnt_reg <= cnt_reg - 1'b1;
                            end else if (n_reg == 4'(DATA_BITS + 1)) begin
                                st_reg <= ABDCS_TX_IDLE;
                            end else begin
                                sh_reg <= {1'b1, sh_reg[9:1]};
                                n_reg <= n_reg + 1'b1;
                                cnt_reg <= bit_div - 1'b1;
                            end
                        end
                        default: st_reg <= ABDCS_TX_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // line outputs from flip-flops, idle high
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_pri_txd <= 1'b1;
            o_sec_txd <= 1'b1;
        end else begin
            o_pri_txd <= tx_line[0];
            o_sec_txd <= tx_line[1];
        end
    end

    assign o_cmd_data = cmd_data_reg;
    assign o_cmd_valid = cmd_valid_reg;
    assign o_rate_locked = locked_reg;
    assign o_rate_sel = rate_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_lock_needs_cr;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(locked_reg) |-> $past(rx_byte_reg) == CHAR_CR;
    endproperty
    a_lock_needs_cr: assert property (p_lock_needs_cr) else $error("lock without cr");
    property p_lock_stays;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        locked_reg |=> locked_reg && $stable(rate_reg);
    endproperty
    a_lock_stays: assert property (p_lock_stays) else $error("rate changed after lock");
    property p_rate_range;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        locked_reg |-> rate_reg < 3'(NUM_RATES);
    endproperty
    a_rate_range: assert property (p_rate_range) else $error("rate out of range");
    property p_no_tx_unlocked;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !locked_reg |-> ##1 (o_pri_txd && o_sec_txd);
    endproperty
    a_no_tx_unlocked: assert property (p_no_tx_unlocked) else $error("tx before lock");
    property p_fwd_cmd;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        cr_seen |=> hold_valid_reg && hold_data_reg == $past(rx_byte_reg);
    endproperty
    a_fwd_cmd: assert property (p_fwd_cmd) else $error("command not forwarded");
    property p_kill;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        fault_rise |=> kill_pend_reg;
    endproperty
    a_kill: assert property (p_kill) else $error("fault did not queue kill");
    property p_cmd_pulse;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        cr_seen |=> o_cmd_valid && o_cmd_data == $past(rx_byte_reg);
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command not delivered");
    property p_start_bit;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        tx_load[1] |=> ##1 !o_sec_txd;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
endmodule : abdcs_serial

// File: pkg/abdcs_pkg.sv
// package of constants and types for the autobaud daisy-chain serial block
package abdcs_pkg;
    // ****************************************************************
    // clock and bit rates
    // ****************************************************************
    localparam int CLK_HZ = 250000000;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 9600;
    localparam int NUM_RATES = 6;
    // divider per bit for each rate, 300 baud first
    localparam int BIT_CYC_300 = CLK_HZ / 300;
    localparam int DIV_W = 20;
    localparam logic [7:0] CHAR_CR = 8'h0d;     // carriage return, 13 decimal
    localparam logic [7:0] CHAR_KILL = 8'h4b;   // kill command byte
    localparam int CHAIN_MAX = 10;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 8;
    // measurement limits: a start bit far from every rate is refused
    localparam int MEAS_MAX = CLK_HZ / BAUD_MIN + CLK_HZ / BAUD_MIN / 4;
    localparam int MEAS_W = 21;
    localparam int SYNC_DEPTH = 3;

    typedef enum {
        ABDCS_HUNT,
        ABDCS_MEAS,
        ABDCS_CHECK,
        ABDCS_LOCK
    } abdcs_baud_e;

    typedef enum {
        ABDCS_RX_IDLE,
        ABDCS_RX_START,
        ABDCS_RX_DATA,
        ABDCS_RX_STOP
    } abdcs_rx_e;

    typedef enum {
        ABDCS_TX_IDLE,
        ABDCS_TX_SHIFT
    } abdcs_tx_e;

    // bit period of rate index k (0 = 300 baud .. 5 = 9600 baud)
    function automatic logic [DIV_W-1:0] abdcs_rate_div(input logic [2:0] k);
        abdcs_rate_div = DIV_W'(BIT_CYC_300 >> k);
    endfunction : abdcs_rate_div
endpackage : abdcs_pkg

// File: pkg/abdcs_stream_if.sv
// byte stream carrier between the serial core and its fifo
`timescale 1ns/1ps
interface abdcs_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : abdcs_stream_if

// File: verilog/abdcs_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module abdcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    abdcs_stream_if.snk s_in,
    abdcs_stream_if.src s_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // honest full and empty straight from the count
    assign s_in.ready = (count_reg != (AW+1)'(DEPTH));
    assign s_out.valid = (count_reg != '0);
    assign s_out.data = mem_reg[rd_ptr_reg];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    // storage write
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= s_in.data;
        end
    end

    // pointers wrap by depth, depth need not be a power of two
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    property p_no_overflow;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        count_reg == (AW+1)'(DEPTH) |-> !s_in.ready;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo takes data while full");
endmodule : abdcs_fifo

// File: sim/abdcs_host_model.sv
// host serial port model and a line monitor for serial frames
`timescale 1ns/1ps
// ****************************************************************
// host transmitter: line idles high, frames sent 8n1 lsb first
// ****************************************************************
module abdcs_host_model (
    input wire logic i_clk_sys,
    output logic o_txd
);
    initial o_txd = 1'b1;
    // changes only at the falling edge, each bit held bit_cyc cycles
    task automatic send(input int bit_cyc, input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk_sys);
            o_txd = frame[i];
            repeat (bit_cyc - 1) @(negedge i_clk_sys);
        end
    endtask : send
endmodule : abdcs_host_model

// ****************************************************************
// frame monitor: samples mid-bit, reports byte and stop level
// ****************************************************************
module abdcs_line_mon #(parameter int BIT_CYC = 26041) (
    input wire logic i_clk_sys,
    input wire logic i_line,
    output logic [7:0] o_byte,
    output logic o_stop,
    output logic o_stb
);
    initial o_stb = 1'b0;
    // a frame at a wrong rate lands the samples on the wrong bits
    always begin
        @(negedge i_line);
        repeat (BIT_CYC / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_clk_sys);
            o_byte[i] = i_line;
        end
        repeat (BIT_CYC) @(posedge i_clk_sys);
        o_stop = i_line;
        o_stb = 1'b1;
        @(posedge i_clk_sys);
        o_stb = 1'b0;
    end
endmodule : abdcs_line_mon

// File: sim/abdcs_serial_test.sv
// self-checking testbench of the autobaud daisy-chain serial block
`timescale 1ns/1ps
module abdcs_serial_test;
    import abdcs_pkg::*;
    localparam int BIT9600 = (CLK_HZ / 300) >> 5;
    logic i_clk_sys, i_sys_rst, i_pri_rxd, o_pri_txd, o_sec_txd, i_fault;
    logic [7:0] o_cmd_data, i_resp_data, pri_byte, sec_byte;
    logic o_cmd_valid, i_resp_valid, o_resp_ready, o_rate_locked;
    logic [2:0] o_rate_sel;
    logic pri_stop, sec_stop, pri_stb, sec_stb;
    logic [7:0] exp_cmd[$], exp_pri[$], exp_sec[$];
    logic [7:0] cmd, rsp;
    int err_total = 0;
    int compares = 0;

    abdcs_serial dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pri_rxd(i_pri_rxd),
        .o_pri_txd(o_pri_txd), .o_sec_txd(o_sec_txd), .i_fault(i_fault),
        .o_cmd_data(o_cmd_data), .o_cmd_valid(o_cmd_valid), .i_resp_data(i_resp_data),
        .i_resp_valid(i_resp_valid), .o_resp_ready(o_resp_ready),
        .o_rate_locked(o_rate_locked), .o_rate_sel(o_rate_sel));
    abdcs_host_model host (.i_clk_sys(i_clk_sys), .o_txd(i_pri_rxd));
    abdcs_line_mon #(.BIT_CYC(BIT9600)) pri_mon (.i_clk_sys(i_clk_sys), .i_line(o_pri_txd),
        .o_byte(pri_byte), .o_stop(pri_stop), .o_stb(pri_stb));
    abdcs_line_mon #(.BIT_CYC(BIT9600)) sec_mon (.i_clk_sys(i_clk_sys), .i_line(o_sec_txd),
        .o_byte(sec_byte), .o_stop(sec_stop), .o_stb(sec_stb));

    // ****************************************************************
    // compare tasks and closing
    // ****************************************************************
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // ****************************************************************
    // result watchers: oldest note against each result seen
    // ****************************************************************
    // an empty queue compares against x so a stray byte always counts
    always @(posedge i_clk_sys) begin
        if (o_cmd_valid === 1'b1) begin
            chk_byte(o_cmd_data, exp_cmd.size() ? exp_cmd.pop_front() : 8'hxx);
        end
    end
    always @(posedge pri_stb) begin
        chk_byte(pri_byte, exp_pri.size() ? exp_pri.pop_front() : 8'hxx);
        chk_bit(pri_stop, 1'b1);
    end
    // same bit period on the secondary shows its rate follows the primary
    always @(posedge sec_stb) begin
        chk_byte(sec_byte, exp_sec.size() ? exp_sec.pop_front() : 8'hxx);
        chk_bit(sec_stop, 1'b1);
    end

    // ****************************************************************
    // main sequence, inputs change at the falling edge
    // ****************************************************************
    initial begin
        i_sys_rst = 1'b1;
        i_fault = 1'b0;
        i_resp_valid = 1'b0;
        i_resp_data = 8'h00;
        void'($urandom(32));
        repeat (20) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        repeat (10) @(negedge i_clk_sys);
        chk_bit(o_resp_ready, 1'b0);
        host.send(BIT9600, CHAR_CR);
        repeat (BIT9600) @(negedge i_clk_sys);
        chk_bit(o_rate_locked, 1'b1);
        chk_byte({5'h00, o_rate_sel}, 8'h05);
        cmd = 8'($urandom);
        exp_cmd.push_back(cmd);
        exp_sec.push_back(cmd);
        host.send(BIT9600, cmd);
        // response and fault overlap the forwarding of the command
        rsp = 8'($urandom);
        exp_pri.push_back(rsp);
        exp_sec.push_back(CHAR_KILL);
        i_resp_data = rsp;
        i_resp_valid = 1'b1;
        i_fault = 1'b1;
        // look at ready off the edge, where it has settled
        #1;
        for (int n = 0; n < 100 && o_resp_ready !== 1'b1; n++) begin
            @(negedge i_clk_sys);
            #1;
        end
        chk_bit(o_resp_ready, 1'b1);
        @(negedge i_clk_sys);
        i_resp_valid = 1'b0;
        for (int n = 0; n < 800000 && (exp_sec.size() || exp_pri.size()); n++) begin
            @(negedge i_clk_sys);
        end
        repeat (BIT9600) @(negedge i_clk_sys);
        chk_byte(8'(exp_sec.size() + exp_pri.size() + exp_cmd.size()), 8'h00);
        wrap_up();
    end

    // cuts a hang short: the run needs about 1.1 million cycles
    initial begin
        repeat (2500000) @(posedge i_clk_sys);
        err_total++;
        wrap_up();
    end
endmodule : abdcs_serial_test
